// >>> logic/cbc_pkg.sv
package cbc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned BLAST_MIN_NS = 800;
    localparam int unsigned BLAST_CYCLES = (BLAST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ACK_LEAD_NS = 10;
    localparam int unsigned ACK_LEAD_CYCLES = (ACK_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 8;

    // ------------------------------------------------------------
    // Cause bit positions
    // ------------------------------------------------------------
    localparam int unsigned CAUSE_W = 6;
    localparam int unsigned CAUSE_PARITY = 0;
    localparam int unsigned CAUSE_ADDR = 1;
    localparam int unsigned CAUSE_TIMEOUT = 2;
    localparam int unsigned CAUSE_HOLD = 3;
    localparam int unsigned CAUSE_IO_INCOMPLETE = 4;
    localparam int unsigned CAUSE_CS_INCOMPLETE = 5;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CBC_IDLE = 4'b0001,
        CBC_ACK = 4'b0010,
        CBC_BLAST = 4'b0100,
        CBC_WAIT = 4'b1000
    } cbc_state_e;

endpackage

// >>> logic/cbc_blast.sv
// Notes on behaviour
// RQ1 - Blast is command tag plus acknowledge tag with transfer strobe held inactive.
// RQ2 - Parity error, invalid device address or channel time-out starts a blast.
// RQ3 - One attachment holding the channel without release starts a blast.
// RQ4 - I/O instruction or cycle steal ending abnormally starts a blast.
// RQ5 - Blast tags stay asserted at least 800 ns.
// RQ6 - Acknowledge tag rises first, command tag follows.
// RQ7 - Attachments stop driving inbound tags and address register select bus.
// RQ8 - Attachments release all sixteen data bus lines.
// RQ9 - Attachments drop transfer response and multiple-device response.
// RQ10 - Attachment in cycle steal drops its burst request.
// RQ11 - Pending interrupt and cycle steal requests stay asserted during blast.
// RQ12 - After attachments release the channel, both tags drop and work resumes.
// RQ13 - Attachment restarts the interrupted operation after the blast.
// RQ14 - Attachments finish releasing well inside the minimum blast time; the slow model releases after 90 blast cycles, past the 80 minimum.
module cbc_blast (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic parity_err_i,
    input wire logic addr_invalid_i,
    input wire logic timeout_i,
    input wire logic owner_stuck_i,
    input wire logic io_incomplete_i,
    input wire logic cs_incomplete_i,
    input wire logic xfer_resp_i,
    input wire logic multi_resp_i,
    input wire logic burst_req_i,
    input wire logic host_cmd_req_i,
    input wire logic host_ack_req_i,
    input wire logic host_strobe_req_i,
    output logic host_cmd_tag_o,
    output logic host_ack_tag_o,
    output logic xfer_strobe_o,
    output logic blast_active_o,
    output logic blast_done_o,
    output logic [cbc_pkg::CAUSE_W-1:0] cause_o
);
    import cbc_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int unsigned SYNC_W = CAUSE_W + 3;
    // Bit order: six causes first, then the three attachment responses
    wire [SYNC_W-1:0] raw_in = {burst_req_i, multi_resp_i, xfer_resp_i, cs_incomplete_i, io_incomplete_i,
                                owner_stuck_i, timeout_i, addr_invalid_i, parity_err_i};
    wire [SYNC_W-1:0] sync_q;

    // Each cause and response pin gets its own two-stage chain; only the second stage is read
    for (genvar gi = 0; gi < SYNC_W; gi++) begin : g_sync
        logic meta_r;
        logic stable_r;

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                meta_r <= 1'b0;
                stable_r <= 1'b0;
            end else begin
                meta_r <= raw_in[gi];
                stable_r <= meta_r;
            end
        end

        assign sync_q[gi] = stable_r;
    end

    // ------------------------------------------------------------
    // Cause decode
    // ------------------------------------------------------------
    wire [CAUSE_W-1:0] cause_now = sync_q[CAUSE_W-1:0];
    wire err_parity = cause_now[CAUSE_PARITY];
    wire err_addr = cause_now[CAUSE_ADDR];
    wire err_timeout = cause_now[CAUSE_TIMEOUT];
    wire err_chan = err_parity | err_addr | err_timeout; // RQ2
    wire err_hold = cause_now[CAUSE_HOLD]; // RQ3
    wire err_io = cause_now[CAUSE_IO_INCOMPLETE];
    wire err_cs = cause_now[CAUSE_CS_INCOMPLETE];
    wire err_incomplete = err_io | err_cs; // RQ4
    wire start_blast = err_chan | err_hold | err_incomplete;

    // ------------------------------------------------------------
    // Channel release
    // ------------------------------------------------------------
    wire resp_seen = sync_q[CAUSE_W];
    wire multi_seen = sync_q[CAUSE_W+1];
    wire burst_seen = sync_q[CAUSE_W+2];
    // Channel counts as released when no response or burst request is still up
    wire chan_busy = resp_seen | multi_seen | burst_seen;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    cbc_state_e state_r;
    cbc_state_e state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CAUSE_W-1:0] cause_r;
    logic [CAUSE_W-1:0] cause_nxt;
    logic done_nxt;

    // State decode
    wire st_ack = (state_r == CBC_ACK);
    wire st_blast = (state_r == CBC_BLAST);
    wire st_wait = (state_r == CBC_WAIT);
    wire cnt_last = (cnt_r == CNT_W'(1));

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        cause_nxt = cause_r;
        done_nxt = 1'b0;
        unique case (state_r)
            CBC_IDLE: begin
                // A cause still up after a release starts the next blast at once
                if (start_blast) begin
                    state_nxt = CBC_ACK; // RQ6
                    cnt_nxt = CNT_W'(ACK_LEAD_CYCLES);
                    cause_nxt = cause_now;
                end
            end
            CBC_ACK: begin
                // Acknowledge leads, command follows
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_last) begin
                    state_nxt = CBC_BLAST; // RQ6
                    cnt_nxt = CNT_W'(BLAST_CYCLES);
                end
            end
            CBC_BLAST: begin
                // Late causes are kept but start nothing new
                cause_nxt = cause_r | cause_now;
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_last) begin
                    state_nxt = CBC_WAIT; // RQ5
                end
            end
            CBC_WAIT: begin
                // Tags hold past the minimum until every attachment has let go
                cause_nxt = cause_r | cause_now;
                if (!chan_busy) begin
                    state_nxt = CBC_IDLE; // RQ12
                    done_nxt = 1'b1;
                end
            end
            default: begin
                // Lost one-hot code: fall back to idle
                state_nxt = CBC_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Tag drive
    // ------------------------------------------------------------
    wire in_blast = st_blast || st_wait;
    wire blast_seq = in_blast || st_ack;
    wire idle_nxt = (state_nxt == CBC_IDLE);
    wire active_nxt = !idle_nxt;
    wire pair_nxt = (state_nxt == CBC_BLAST) || (state_nxt == CBC_WAIT);
    // Host requests pass only while idle, one cycle late
    wire pass_ok = idle_nxt && !blast_seq;
    // Command plus acknowledge without strobe would read as a blast too short to count
    wire host_pair_bad = host_cmd_req_i && host_ack_req_i && !host_strobe_req_i; // RQ5
    wire ack_nxt = active_nxt || (host_ack_req_i && pass_ok); // RQ6
    wire cmd_nxt = pair_nxt || (host_cmd_req_i && !host_pair_bad && pass_ok); // RQ1
    wire strobe_nxt = host_strobe_req_i && pass_ok; // RQ1

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= CBC_IDLE;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Cause capture
    // ------------------------------------------------------------
    // Reloaded at each blast start, otherwise only gathers more causes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cause_r <= '0;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // ------------------------------------------------------------
    // Channel tags
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_cmd_tag_o <= 1'b0;
            host_ack_tag_o <= 1'b0;
            xfer_strobe_o <= 1'b0;
        end else begin
            host_cmd_tag_o <= cmd_nxt;
            host_ack_tag_o <= ack_nxt;
            xfer_strobe_o <= strobe_nxt;
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    // Done pulses in the cycle the tags drop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blast_active_o <= 1'b0;
            blast_done_o <= 1'b0;
            cause_o <= '0;
        end else begin
            blast_active_o <= active_nxt;
            blast_done_o <= done_nxt;
            cause_o <= cause_nxt;
        end
    end

endmodule // cbc_blast

// >>> test/cbc_blast_props.sv
module cbc_blast_props (
    input wire logic clk_i, rst_n_i, parity_err_i, addr_invalid_i, timeout_i, owner_stuck_i,
    input wire logic io_incomplete_i, cs_incomplete_i, xfer_resp_i, multi_resp_i, burst_req_i,
    input wire logic host_cmd_tag_o, host_ack_tag_o, xfer_strobe_o, blast_active_o, blast_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import cbc_pkg::*;
    logic [7:0] cnt_r;
    wire logic err_w = parity_err_i | addr_invalid_i | timeout_i;
    wire logic inc_w = io_incomplete_i | cs_incomplete_i;
    wire logic resp_w = xfer_resp_i | multi_resp_i | burst_req_i;
    // Cycles with both tags up in the current run
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i) cnt_r <= 8'h00;
        else cnt_r <= (host_cmd_tag_o && host_ack_tag_o) ? cnt_r + 8'h01 : 8'h00;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_NO_STROBE: assert property (blast_active_o |-> !xfer_strobe_o) else $error("strobe in blast");
    AST_PAIR_IS_BLAST: assert property (host_cmd_tag_o && host_ack_tag_o && !xfer_strobe_o |-> blast_active_o)
        else $error("blast pair outside blast");
    AST_ERR_START: assert property ($rose(err_w) && !blast_active_o |-> ##[1:5] blast_active_o)
        else $error("no blast on error");
    AST_STUCK_START: assert property ($rose(owner_stuck_i) && !blast_active_o |-> ##[1:5] blast_active_o)
        else $error("no blast on stuck owner");
    AST_INC_START: assert property ($rose(inc_w) && !blast_active_o |-> ##[1:5] blast_active_o)
        else $error("no blast on incomplete");
    AST_MIN_TIME: assert property (blast_done_o |-> cnt_r >= BLAST_CYCLES) else $error("blast short");
    AST_ACK_LEAD: assert property ($rose(blast_active_o) |-> host_ack_tag_o && !host_cmd_tag_o ##1 host_cmd_tag_o)
        else $error("tag order");
    AST_HOLD_OFF: assert property ((blast_active_o && resp_w) [*4] |-> !blast_done_o)
        else $error("release while busy");
    AST_DROP: assert property (blast_done_o |-> !host_cmd_tag_o && !host_ack_tag_o && $past(host_cmd_tag_o))
        else $error("tags not dropped");
    cover property ($rose(blast_active_o));
    cover property (blast_done_o && cnt_r > 8'h5a);
    cover property (host_cmd_tag_o && !blast_active_o);
endmodule // cbc_blast_props
bind cbc_blast cbc_blast_props u_props (.*);

// >>> test/cbc_attach_model.sv
module cbc_attach_model (
    input wire logic clk_i, rst_n_i, cmd_i, ack_i, strobe_i, busy_i, slow_i,
    output logic resp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_r;
    logic pend_r;
    wire logic blast_w = cmd_i && ack_i && !strobe_i;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_r <= 8'h00;
            pend_r <= 1'b0;
            resp_o <= 1'b0;
        end else if (blast_w) begin
            wait_r <= wait_r + 8'h01;
            pend_r <= pend_r;
            // Response stands for every line the attachment drives
            if (wait_r == (slow_i ? 8'h5a : 8'h02)) resp_o <= 1'b0;
        end else begin
            wait_r <= 8'h00;
            pend_r <= busy_i;
            resp_o <= busy_i || pend_r;
        end
    end
endmodule // cbc_attach_model

// >>> test/channel_blast_clear_test.sv
module channel_blast_clear_test;
    timeunit 1ns;
    timeprecision 1ps;
    import cbc_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, busy = 1'b0, slow = 1'b0;
    logic [5:0] cause = 6'h00;
    logic [2:0] req = 3'h0;
    logic resp, cmd, ack, stb, active, done;
    logic [CAUSE_W-1:0] cause_o;
    logic [CAUSE_W-1:0] exp_q[$];
    int n_fail = 0, check_count = 0, len = 0;
    cbc_blast DUT (.clk_i, .rst_n_i, .parity_err_i(cause[0]), .addr_invalid_i(cause[1]), .timeout_i(cause[2]),
        .owner_stuck_i(cause[3]), .io_incomplete_i(cause[4]), .cs_incomplete_i(cause[5]), .xfer_resp_i(resp),
        .multi_resp_i(resp), .burst_req_i(resp), .host_cmd_req_i(req[2]), .host_ack_req_i(req[1]),
        .host_strobe_req_i(req[0]), .host_cmd_tag_o(cmd), .host_ack_tag_o(ack), .xfer_strobe_o(stb),
        .blast_active_o(active), .blast_done_o(done), .cause_o);
    cbc_attach_model PTR (.clk_i, .rst_n_i, .cmd_i(cmd), .ack_i(ack), .strobe_i(stb), .busy_i(busy),
        .slow_i(slow), .resp_o(resp));
    initial forever #5 clk_i = ~clk_i;
    task automatic chk(string name, logic [7:0] e, logic [7:0] s);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, e, s);
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wait_for(ref logic s);
        int k;
        for (k = 0; k < 400 && s !== 1'b1; k++) @(negedge clk_i);
        if (k == 400) begin
            n_fail++;
            end_of_test();
        end
    endtask
    // Watches each finished blast against the oldest note
    always @(negedge clk_i) begin
        if (done === 1'b1) begin
            chk("blast_len", 8'h01, 8'(len >= BLAST_CYCLES));
            chk("cause_o", 8'(exp_q.pop_front()), 8'(cause_o));
            len = 0;
        end else if (active === 1'b1 && cmd === 1'b1) len++;
    end
    initial begin
        void'($urandom(98));
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (40) begin
            req = 3'($urandom());
            @(negedge clk_i);
            chk("tags", 8'({req[2] && !(req[1] && !req[0]), req[1:0]}), 8'({cmd, ack, stb}));
        end
        busy = 1'b1;
        for (int i = 0; i < CAUSE_W; i++) begin
            slow = 1'($urandom());
            req = 3'($urandom());
            exp_q.push_back(6'(1 << i));
            cause[i] = 1'b1;
            wait_for(active);
            cause[i] = 1'b0;
            wait_for(done);
        end
        @(negedge clk_i);
        chk("notes_left", 8'h00, 8'(exp_q.size()));
        end_of_test();
    end
endmodule // channel_blast_clear_test
